// ---- verilog/dlp_pkg.sv ----
// Constants, types and register map of the display list processor.
// Assumes one clock domain; every user writes dlp_pkg::name.
// Function
// - After a vector, its end point becomes the new current beam position.
// - Vectors draw solid, long dash, short dash or dot-dash.
// - Show 96 printable characters plus 31 specials chosen by shift-out/shift-in.
// - Characters slant when the italics status bit is set.
// - Eight programmable brightness levels.
// - Five control instructions and seven data formats steer interpretation and flow.
// - Decode set mode, jump, no-operation, load status A, load status B.
// - Two chars per word; short vector one word; long vector, point two.
// - Graph mode: data sets one axis, the other steps by preset spacing.
// - 16-bit list words; 10-bit coordinates, visible 1024 by 768.
// - Program-enabled blink blanks beam_on_o for any drawn element; glyph_valid_o still pulses for characters.
// - Line clock input lets refresh wait for mains, selectable by program.
// - Descender characters sit lower than the baseline.
// - Carriage return, line feed, backspace move the position and draw nothing.
package dlp_pkg;
   // ==========================================================
   // Register offsets and control bits
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_START  = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_POSX   = 3'h3;
   localparam logic [2:0] REG_POSY   = 3'h4;
   localparam int         CTRL_RUN   = 0;
   localparam int         CTRL_STOP  = 1;
   // ==========================================================
   // Control instruction opcodes, word bits 14:12 when bit 15 is set
   localparam logic [2:0] OP_MODE                     = 3'h0;
   localparam logic [2:0] OP_JUMP                     = 3'h1;
   localparam logic [2:0] OP_NO_OPERATION_INSTRUCTION = 3'h2;
   localparam logic [2:0] OP_STA                      = 3'h3;
   localparam logic [2:0] OP_STB                      = 3'h4;
   typedef enum logic [2:0] {M_CHAR, M_SVEC, M_LVEC, M_POINT, M_GRAPHX, M_GRAPHY, M_RPOINT} mode_t;
   localparam logic [1:0] K_INSTR  = 2'h0;
   localparam logic [1:0] K_JUMP   = 2'h1;
   localparam logic [1:0] K_SECOND = 2'h2;
   // ==========================================================
   // Geometry and characters
   localparam logic [9:0] Y_LIMIT     = 10'h300;
   localparam logic [9:0] CHAR_W      = 10'h00e;
   localparam logic [9:0] LINE_H      = 10'h018;
   localparam logic [9:0] DESC_OFS    = 10'h004;
   localparam logic [9:0] SPACING_RST = 10'h001;
   localparam logic [6:0] CH_BS       = 7'h08;
   localparam logic [6:0] CH_LF       = 7'h0a;
   localparam logic [6:0] CH_CR       = 7'h0d;
   localparam logic [6:0] CH_SO       = 7'h0e;
   localparam logic [6:0] CH_SI       = 7'h0f;
   localparam logic [6:0] CH_FIRST    = 7'h20;
   localparam logic [6:0] SPEC_LAST   = 7'h3e;
   localparam logic [3:0] BLINK_EDGES = 4'hf;
   // ==========================================================
   // Line style patterns, one bit per generated step
   localparam logic [15:0] PAT_SOLID   = 16'hffff;
   localparam logic [15:0] PAT_LONG    = 16'hfff0;
   localparam logic [15:0] PAT_SHORT   = 16'hcccc;
   localparam logic [15:0] PAT_DOTDASH = 16'hfe38;
endpackage

// ---- verilog/vec_if.sv ----
// Link between the list sequencer and the vector generator.
// Assumes both ends share mclk_i.
`timescale 1ns/1ps
`default_nettype none
interface vec_if;
   logic       start;
   logic [9:0] x0;
   logic [9:0] y0;
   logic [9:0] x1;
   logic [9:0] y1;
   logic       step;
   logic       done;
   logic [9:0] px;
   logic [9:0] py;
   modport gen (input start, x0, y0, x1, y1, output step, done, px, py);
   modport ctl (output start, x0, y0, x1, y1, input step, done, px, py);
endinterface
`default_nettype wire

// ---- verilog/vector_gen.sv ----
// Integer line walker: one raster point per clock from start to end.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`default_nettype none
module vector_gen (
   input wire logic mclk_i,
   input wire logic rst_i,
   vec_if.gen       vif
);
   typedef struct packed {
      logic              busy;
      logic [9:0]        x;
      logic [9:0]        y;
      logic [9:0]        ex;
      logic [9:0]        ey;
      logic signed [12:0] adx;
      logic signed [12:0] ady;
      logic              sx;
      logic              sy;
      logic signed [12:0] err;
   } gen_t;
   gen_t s_r;
   gen_t s_nxt;
   logic at_end;

   assign at_end   = (s_r.x == s_r.ex) && (s_r.y == s_r.ey);
   assign vif.step = s_r.busy;
   assign vif.done = s_r.busy && at_end;
   assign vif.px   = s_r.x;
   assign vif.py   = s_r.y;

   always_comb begin
      logic signed [12:0] e2;
      e2    = {s_r.err[11:0], 1'b0};
      s_nxt = s_r;
      if (vif.start) begin
         s_nxt.busy = 1'b1;
         s_nxt.x    = vif.x0;
         s_nxt.y    = vif.y0;
         s_nxt.ex   = vif.x1;
         s_nxt.ey   = vif.y1;
         s_nxt.sx   = vif.x1 < vif.x0;
         s_nxt.sy   = vif.y1 < vif.y0;
         s_nxt.adx  = {3'h0, (vif.x1 < vif.x0) ? vif.x0 - vif.x1 : vif.x1 - vif.x0};
         s_nxt.ady  = {3'h0, (vif.y1 < vif.y0) ? vif.y0 - vif.y1 : vif.y1 - vif.y0};
         s_nxt.err  = s_nxt.adx - s_nxt.ady;
      end else if (s_r.busy) begin
         // Stopping on the exact end coordinate keeps successive vectors free of drift.
         if (at_end) begin
            s_nxt.busy = 1'b0;
         end else begin
            if (e2 > -s_r.ady) begin
               s_nxt.err = s_nxt.err - s_r.ady;
               s_nxt.x   = s_r.sx ? s_r.x - 10'h001 : s_r.x + 10'h001;
            end
            if (e2 < s_r.adx) begin
               s_nxt.err = s_nxt.err + s_r.adx;
               s_nxt.y   = s_r.sy ? s_r.y - 10'h001 : s_r.y + 10'h001;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/display_list_proc.sv ----
// Display list processor: fetches 16-bit list words, decodes control
// instructions and data formats, and drives beam position, intensity and glyphs.
// Assumes memory answers a held read with a one-cycle ack carrying the word.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module display_list_proc (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic [2:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output var  logic [15:0] reg_rdata_o,
   output var  logic        mem_rd_o,
   output var  logic [15:0] mem_addr_o,
   input  wire logic [15:0] mem_rdata_i,
   input  wire logic        mem_ack_i,
   input  wire logic        line_clk_i,
   output var  logic [9:0]  beam_x_o,
   output var  logic [9:0]  beam_y_o,
   output var  logic        beam_on_o,
   output var  logic [2:0]  intensity_o,
   output var  logic        glyph_valid_o,
   output var  logic [7:0]  glyph_code_o,
   output var  logic        glyph_italic_o
);
   // ==========================================================
   // State
   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CHAR2, S_VEC, S_SYNC} state_t;
   typedef struct packed {
      state_t          st;
      logic [1:0]      kind;
      logic            run;
      logic [15:0]     pc;
      logic [15:0]     start;
      dlp_pkg::mode_t  mode;
      logic [2:0]      intens;
      logic            blink;
      logic [1:0]      style;
      logic            italic;
      logic            sync_en;
      logic [9:0]      spacing;
      logic            shift_out;
      logic [9:0]      cx;
      logic [9:0]      cy;
      logic [15:0]     w1;
      logic [6:0]      hold;
      logic            lclk_d;
      logic [3:0]      bl_cnt;
      logic            bl_ph;
      logic [3:0]      sidx;
      logic            vstart;
      logic            vdraw;
      logic [9:0]      vx1;
      logic [9:0]      vy1;
      logic [15:0]     rdata;
      logic            mem_rd;
      logic [9:0]      bx;
      logic [9:0]      by;
      logic            bon;
      logic            gv;
      logic [7:0]      gcode;
      logic            gital;
   } dp_t;
   dp_t s_r;
   dp_t s_nxt;
   vec_if vif ();

   vector_gen u_vec (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .vif    (vif)
   );

   assign vif.start = s_r.vstart;
   assign vif.x0    = s_r.cx;
   assign vif.y0    = s_r.cy;
   assign vif.x1    = s_r.vx1;
   assign vif.y1    = s_r.vy1;

   // ==========================================================
   // Helpers
   // Sign-magnitude field to a wrapping 10-bit displacement.
   function automatic logic [9:0] smag(input logic sgn, input logic [8:0] mag);
      smag = sgn ? 10'h000 - {1'b0, mag} : {1'b0, mag};
   endfunction

   function automatic logic style_bit(input logic [1:0] sty, input logic [3:0] idx);
      case (sty)
         2'h0:    style_bit = dlp_pkg::PAT_SOLID[idx];
         2'h1:    style_bit = dlp_pkg::PAT_LONG[idx];
         2'h2:    style_bit = dlp_pkg::PAT_SHORT[idx];
         default: style_bit = dlp_pkg::PAT_DOTDASH[idx];
      endcase
   endfunction

   // Puts a point on the beam; blanks above the visible area and in the blink off phase.
   function automatic dp_t plot(input dp_t s, input logic [9:0] x, input logic [9:0] y, input logic on);
      dp_t r;
      r     = s;
      r.bx  = x;
      r.by  = y;
      r.bon = on && (y < dlp_pkg::Y_LIMIT) && (!s.blink || s.bl_ph);
      return r;
   endfunction

   function automatic logic is_desc(input logic [6:0] c);
      is_desc = (c == 7'h67) || (c == 7'h6a) || (c == 7'h70) || (c == 7'h71) || (c == 7'h79);
   endfunction

   function automatic dp_t do_char(input dp_t s, input logic [6:0] c);
      dp_t        r;
      logic [9:0] gy;
      r  = s;
      gy = is_desc(c) ? s.cy - dlp_pkg::DESC_OFS : s.cy;
      case (c)
         dlp_pkg::CH_CR: r.cx = 10'h000;
         dlp_pkg::CH_LF: r.cy = s.cy - dlp_pkg::LINE_H;
         dlp_pkg::CH_BS: r.cx = s.cx - dlp_pkg::CHAR_W;
         dlp_pkg::CH_SO: r.shift_out = 1'b1;
         dlp_pkg::CH_SI: r.shift_out = 1'b0;
         default: begin
            if (c >= dlp_pkg::CH_FIRST) begin
               r       = plot(r, s.cx, gy, 1'b1);
               r.gv    = 1'b1;
               // Specials occupy the bottom 31 printable codes while shifted out.
               r.gcode = {s.shift_out && (c <= dlp_pkg::SPEC_LAST), c};
               r.gital = s.italic;
               r.cx    = s.cx + dlp_pkg::CHAR_W;
            end
         end
      endcase
      return r;
   endfunction

   function automatic dp_t go_fetch(input dp_t s, input logic [1:0] k);
      dp_t r;
      r        = s;
      r.st     = S_FETCH;
      r.mem_rd = 1'b1;
      r.kind   = k;
      return r;
   endfunction

   // ==========================================================
   // Sequencer
   always_comb begin
      logic [15:0] w;
      logic        ledge;
      logic [9:0]  dx;
      logic [9:0]  dy;
      w        = mem_rdata_i;
      ledge    = line_clk_i && !s_r.lclk_d;
      dx       = smag(w[13], {3'h0, w[12:7]});
      dy       = smag(w[6], {3'h0, w[5:0]});
      s_nxt        = s_r;
      s_nxt.lclk_d = line_clk_i;
      s_nxt.bon    = 1'b0;
      s_nxt.gv     = 1'b0;
      s_nxt.vstart = 1'b0;
      s_nxt.rdata  = 16'h0000;
      if (ledge) begin
         s_nxt.bl_cnt = s_r.bl_cnt + 4'h1;
         if (s_r.bl_cnt == dlp_pkg::BLINK_EDGES) begin
            s_nxt.bl_ph = !s_r.bl_ph;
         end
      end
      case (s_r.st)
         S_IDLE: begin
         end
         S_FETCH: begin
            if (mem_ack_i) begin
               s_nxt.mem_rd = 1'b0;
               s_nxt.pc     = s_r.pc + 16'h0001;
               s_nxt        = go_fetch(s_nxt, dlp_pkg::K_INSTR);
               if (s_r.kind == dlp_pkg::K_JUMP) begin
                  s_nxt.pc = w;
                  if (s_r.sync_en) begin
                     // Holding the frame loop until the mains edge locks refresh to the line.
                     s_nxt.st     = S_SYNC;
                     s_nxt.mem_rd = 1'b0;
                  end
               end else if (s_r.kind == dlp_pkg::K_SECOND) begin
                  if (s_r.mode == dlp_pkg::M_LVEC) begin
                     s_nxt.vx1    = s_r.cx + smag(s_r.w1[13], s_r.w1[8:0]);
                     s_nxt.vy1    = s_r.cy + smag(w[13], w[8:0]);
                     s_nxt.vdraw  = s_r.w1[14];
                     s_nxt.vstart = 1'b1;
                     s_nxt.st     = S_VEC;
                     s_nxt.mem_rd = 1'b0;
                  end else begin
                     s_nxt.cx = s_r.w1[9:0];
                     s_nxt.cy = w[9:0];
                     s_nxt    = plot(s_nxt, s_r.w1[9:0], w[9:0], s_r.w1[14]);
                  end
               end else if (w[15]) begin
                  case (w[14:12])
                     dlp_pkg::OP_MODE: begin
                        s_nxt.mode = dlp_pkg::mode_t'(w[2:0]);
                        if (w[3]) begin
                           s_nxt.intens = w[6:4];
                        end
                        if (w[7]) begin
                           s_nxt.blink = w[8];
                        end
                        if (w[9]) begin
                           s_nxt.style = w[11:10];
                        end
                     end
                     dlp_pkg::OP_JUMP: s_nxt.kind = dlp_pkg::K_JUMP;
                     dlp_pkg::OP_NO_OPERATION_INSTRUCTION: begin
                     end
                     dlp_pkg::OP_STA: begin
                        s_nxt.sync_en = w[0];
                        if (w[1]) begin
                           s_nxt.run    = 1'b0;
                           s_nxt.st     = S_IDLE;
                           s_nxt.mem_rd = 1'b0;
                        end
                     end
                     dlp_pkg::OP_STB: begin
                        s_nxt.italic  = w[0];
                        s_nxt.spacing = w[10:1];
                     end
                     default: begin
                     end
                  endcase
               end else begin
                  case (s_r.mode)
                     dlp_pkg::M_CHAR: begin
                        s_nxt        = do_char(s_nxt, w[6:0]);
                        s_nxt.hold   = w[14:8];
                        s_nxt.st     = S_CHAR2;
                        s_nxt.mem_rd = 1'b0;
                     end
                     dlp_pkg::M_SVEC: begin
                        s_nxt.vx1    = s_r.cx + dx;
                        s_nxt.vy1    = s_r.cy + dy;
                        s_nxt.vdraw  = w[14];
                        s_nxt.vstart = 1'b1;
                        s_nxt.st     = S_VEC;
                        s_nxt.mem_rd = 1'b0;
                     end
                     dlp_pkg::M_RPOINT: begin
                        s_nxt.cx = s_r.cx + dx;
                        s_nxt.cy = s_r.cy + dy;
                        s_nxt    = plot(s_nxt, s_r.cx + dx, s_r.cy + dy, w[14]);
                     end
                     dlp_pkg::M_GRAPHX: begin
                        s_nxt.cx = w[9:0];
                        s_nxt.cy = s_r.cy + s_r.spacing;
                        s_nxt    = plot(s_nxt, w[9:0], s_r.cy + s_r.spacing, w[14]);
                     end
                     dlp_pkg::M_GRAPHY: begin
                        s_nxt.cy = w[9:0];
                        s_nxt.cx = s_r.cx + s_r.spacing;
                        s_nxt    = plot(s_nxt, s_r.cx + s_r.spacing, w[9:0], w[14]);
                     end
                     default: begin
                        s_nxt.w1   = w;
                        s_nxt.kind = dlp_pkg::K_SECOND;
                     end
                  endcase
               end
            end
         end
         S_CHAR2: begin
            s_nxt = do_char(s_nxt, s_r.hold);
            s_nxt = go_fetch(s_nxt, dlp_pkg::K_INSTR);
         end
         S_VEC: begin
            if (vif.step) begin
               s_nxt      = plot(s_nxt, vif.px, vif.py, s_r.vdraw && style_bit(s_r.style, s_r.sidx));
               s_nxt.sidx = s_r.sidx + 4'h1;
            end
            if (vif.done) begin
               s_nxt.cx = s_r.vx1;
               s_nxt.cy = s_r.vy1;
               s_nxt    = go_fetch(s_nxt, dlp_pkg::K_INSTR);
            end
         end
         S_SYNC: begin
            if (ledge) begin
               s_nxt = go_fetch(s_nxt, dlp_pkg::K_INSTR);
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase
      // Register writes come last so software start and stop override the sequencer.
      if (reg_wr_i) begin
         case (reg_addr_i)
            dlp_pkg::REG_CTRL: begin
               if (reg_wdata_i[dlp_pkg::CTRL_STOP]) begin
                  s_nxt.run    = 1'b0;
                  s_nxt.st     = S_IDLE;
                  s_nxt.mem_rd = 1'b0;
               end else if (reg_wdata_i[dlp_pkg::CTRL_RUN] && !s_r.run) begin
                  s_nxt.run  = 1'b1;
                  s_nxt.pc   = s_r.start;
                  s_nxt.sidx = 4'h0;
                  s_nxt      = go_fetch(s_nxt, dlp_pkg::K_INSTR);
               end
            end
            dlp_pkg::REG_START: s_nxt.start = reg_wdata_i;
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            dlp_pkg::REG_CTRL:   s_nxt.rdata = {15'h0000, s_r.run};
            dlp_pkg::REG_START:  s_nxt.rdata = s_r.start;
            dlp_pkg::REG_STATUS: s_nxt.rdata = {2'h0, s_r.italic, s_r.sync_en, s_r.blink, s_r.style, s_r.intens,
                                                s_r.mode, s_r.st};
            dlp_pkg::REG_POSX:   s_nxt.rdata = {6'h00, s_r.cx};
            dlp_pkg::REG_POSY:   s_nxt.rdata = {6'h00, s_r.cy};
            default:             s_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r         <= '0;
         s_r.st      <= S_IDLE;
         s_r.mode    <= dlp_pkg::M_CHAR;
         s_r.spacing <= dlp_pkg::SPACING_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o    = s_r.rdata;
   assign mem_rd_o       = s_r.mem_rd;
   assign mem_addr_o     = s_r.pc;
   assign beam_x_o       = s_r.bx;
   assign beam_y_o       = s_r.by;
   assign beam_on_o      = s_r.bon;
   assign intensity_o    = s_r.intens;
   assign glyph_valid_o  = s_r.gv;
   assign glyph_code_o   = s_r.gcode;
   assign glyph_italic_o = s_r.gital;
endmodule
`default_nettype wire

// ---- sim/dlp_mem_model.sv ----
// Shared list memory model for the display list processor bench.
// Assumes one clock; the bench loads words through the words array.
`timescale 1ns/1ps
`default_nettype none
module dlp_mem_model (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        mem_rd_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [1:0]  wait_i,
   output var  logic [15:0] mem_rdata_o,
   output var  logic        mem_ack_o
);
   logic [15:0] words [0:63];
   logic [1:0]  cnt_r;
   initial for (int i = 0; i < 64; i++) words[i] = 16'ha000;
   // ==========================================================
   // Answer
   // Outside the ack cycle the data lines toggle, so a late sample shows up.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 2'h0;
         mem_ack_o <= 1'b0;
         mem_rdata_o <= 16'h0000;
      end else if (mem_rd_i && !mem_ack_o && cnt_r >= wait_i) begin
         cnt_r <= 2'h0;
         mem_ack_o <= 1'b1;
         mem_rdata_o <= words[mem_addr_i[5:0]];
      end else begin
         mem_ack_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         cnt_r <= (mem_rd_i && !mem_ack_o && cnt_r != 2'h3) ? cnt_r + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// ---- sim/dlp_assertions.sv ----
// Port checker for the display list processor.
// Assumes the single clock mclk_i and the asynchronous reset rst_i.
`timescale 1ns/1ps
`default_nettype none
module dlp_checker (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [2:0]  reg_addr_i,
   input wire logic        reg_rd_i,
   input wire logic        reg_wr_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        mem_rd_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic        mem_ack_i,
   input wire logic [9:0]  beam_y_o,
   input wire logic        beam_on_o,
   input wire logic        glyph_valid_o,
   input wire logic [7:0]  glyph_code_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Register port
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 3'h4 |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_pos_width: assert property (reg_rd_i && reg_addr_i == dlp_pkg::REG_POSX |=> reg_rdata_o[15:10] == 6'h00)
      else $error("position wider than 10 bits");
   // ==========================================================
   // List fetch
   a_fetch_held: assert property (mem_rd_o && !mem_ack_i && !reg_wr_i |=> mem_rd_o && $stable(mem_addr_o))
      else $error("fetch dropped before ack");
   a_nop_advance: assert property (mem_rd_o && mem_ack_i && mem_rdata_i[15:12] == 4'ha
      |=> mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
      else $error("no-operation did not move on");
   // ==========================================================
   // Beam and glyphs
   a_beam_visible: assert property (beam_on_o |-> beam_y_o < dlp_pkg::Y_LIMIT)
      else $error("lit point outside visible area");
   a_ctrl_noglyph: assert property (glyph_valid_o |-> glyph_code_o[6:0] >= dlp_pkg::CH_FIRST)
      else $error("glyph drawn for a control code");
   a_special_range: assert property (glyph_valid_o && glyph_code_o[7] |-> glyph_code_o[6:0] <= dlp_pkg::SPEC_LAST)
      else $error("special glyph out of range");
endmodule
bind display_list_proc dlp_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
   .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .beam_y_o(beam_y_o), .beam_on_o(beam_on_o),
   .reg_wr_i(reg_wr_i), .glyph_valid_o(glyph_valid_o), .glyph_code_o(glyph_code_o));
`default_nettype wire

// ---- sim/display_list_proc_tb.sv ----
// Self-checking bench for the display list processor.
// Assumes the memory model answers fetches and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module display_list_proc_tb;
   typedef struct {logic [15:0] w0, w1, w2; logic [9:0] ex, ey; int lit; logic [2:0] inten;} row_t;
   logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, line_clk_i, mem_rd, mem_ack, beam_on, glyph_valid, italic;
   logic [2:0]  reg_addr_i, intensity;
   logic [15:0] reg_wdata_i, reg_rdata, mem_addr, mem_rdata, v;
   logic [9:0]  bx, by;
   logic [7:0]  gcode;
   logic [1:0]  wait_sel;
   logic [31:0] glyphs [$];
   logic [31:0] eg [3];
   row_t        rows [11];
   int          errors = 0, comparisons = 0, lit_cnt = 0;
   display_list_proc uut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
      .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .line_clk_i(line_clk_i), .beam_x_o(bx), .beam_y_o(by),
      .beam_on_o(beam_on), .intensity_o(intensity), .glyph_valid_o(glyph_valid), .glyph_code_o(gcode),
      .glyph_italic_o(italic));
   dlp_mem_model mem (.mclk_i(mclk_i), .rst_i(rst_i), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
      .wait_i(wait_sel), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (glyph_valid === 1'b1) glyphs.push_back({3'h0, italic, gcode, bx, by});
      if (beam_on === 1'b1) lit_cnt++;
   end
   // ==========================================================
   // Tasks
   task automatic close_out();
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic start(input logic [15:0] a);
      wr(dlp_pkg::REG_START, a);
      wr(dlp_pkg::REG_CTRL, 16'h0001);
      wr(dlp_pkg::REG_CTRL, 16'h0000);
   endtask
   task automatic wait_idle();
      int n = 0;
      v = 16'h0001;
      while (v[2:0] !== 3'h0 && n < 400) begin
         rd(dlp_pkg::REG_STATUS, v);
         n++;
      end
      if (n >= 400) begin
         errors++;
         close_out();
      end
   endtask
   // ==========================================================
   // Sequence
   initial begin
      {rst_i, reg_wr_i, reg_rd_i, line_clk_i, reg_addr_i, reg_wdata_i, wait_sel} = {1'b1, 24'h0};
      rows = '{'{16'h8201, 16'h4780, 16'ha000, 10'h00f, 10'h000, 16, 3'h0},
               '{16'h8601, 16'h4780, 16'ha000, 10'h01e, 10'h000, 12, 3'h0},
               '{16'h8a01, 16'h4780, 16'ha000, 10'h02d, 10'h000, 8, 3'h0},
               '{16'h8e01, 16'h4780, 16'ha000, 10'h03c, 10'h000, 10, 3'h0},
               '{16'h825b, 16'h4064, 16'h00c8, 10'h064, 10'h0c8, 1, 3'h5},
               '{16'h8003, 16'h4010, 16'h0300, 10'h010, 10'h300, 0, 3'h5},
               '{16'h8001, 16'h42c3, 16'ha000, 10'h015, 10'h2fd, -1, 3'h5},
               '{16'h8002, 16'h6005, 16'h0020, 10'h010, 10'h31d, -1, 3'h5},
               '{16'h8006, 16'h4141, 16'ha000, 10'h012, 10'h31c, 0, 3'h5},
               '{16'h8005, 16'h4100, 16'h4080, 10'h014, 10'h080, 2, 3'h5},
               '{16'h8004, 16'h4030, 16'h0040, 10'h040, 10'h082, 1, 3'h5}};
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(dlp_pkg::REG_STATUS, v);
      chk("status_reset", 32'h0, v);
      wr(3'h7, 16'hffff);
      rd(3'h7, v);
      chk("unmapped", 32'h0, v);
      for (int i = 0; i < 11; i++) begin
         mem.words[0] = rows[i].w0;
         mem.words[1] = rows[i].w1;
         mem.words[2] = rows[i].w2;
         mem.words[3] = 16'hb002;
         lit_cnt = 0;
         start(16'h0000);
         wait_idle();
         rd(dlp_pkg::REG_POSX, v);
         chk("posx", rows[i].ex, v);
         rd(dlp_pkg::REG_POSY, v);
         chk("posy", rows[i].ey, v);
         if (rows[i].lit >= 0) chk("lit_points", rows[i].lit, lit_cnt);
         chk("intensity", rows[i].inten, intensity);
      end
      // Characters with a slow memory.
      wait_sel = 2'h2;
      glyphs.delete();
      eg[0] = {3'h0, 1'b1, 8'h41, 10'h064, 10'h100};
      eg[1] = {3'h0, 1'b1, 8'h67, 10'h072, 10'h0fc};
      eg[2] = {3'h0, 1'b1, 8'ha1, 10'h000, 10'h100};
      mem.words[16] = 16'h8003;
      mem.words[17] = 16'h0064;
      mem.words[18] = 16'h0100;
      mem.words[19] = 16'hc001;
      mem.words[20] = 16'h8000;
      mem.words[21] = 16'h6741;
      mem.words[22] = 16'h0d08;
      mem.words[23] = 16'h210e;
      mem.words[24] = 16'hb002;
      start(16'h0010);
      wait_idle();
      chk("glyph_count", 32'd3, glyphs.size());
      for (int i = 0; i < 3 && i < glyphs.size(); i++) chk("glyph", eg[i], glyphs[i]);
      rd(dlp_pkg::REG_POSX, v);
      chk("char_posx", 32'h00e, v);
      // Jump with line sync on must hold until a mains edge arrives.
      wait_sel = 2'h0;
      mem.words[32] = 16'hb001;
      mem.words[34] = 16'h9000;
      mem.words[35] = 16'h0028;
      mem.words[36] = 16'hb002;
      mem.words[40] = 16'hb002;
      start(16'h0020);
      repeat (30) @(posedge mclk_i);
      rd(dlp_pkg::REG_STATUS, v);
      chk("sync_wait", 32'h4, v[2:0]);
      line_clk_i <= 1'b1;
      wait_idle();
      chk("sync_done", 32'h0, v[2:0]);
      close_out();
   end
   initial begin
      #(8 * 90000);
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
